// file: include/mcd_pkg.sv
// How it works
// RULE1 - new gain is old times expected/measured, checked
// RULE2 - each range count adds one right shift
// RULE3 - gains are sixteen bits, unsigned
// RULE4 - sub-sample delay, 256 steps per sample
// RULE5 - phase term is signed low byte
// RULE6 - ac offsets for current, active, reactive
// RULE7 - dc mode bypasses both high-pass filters
// RULE8 - dc offsets for current and active power
// RULE9 - channel offset is upper byte plus word
// RULE10 - voltage byte high, current byte low
// RULE11 - offset added to converter code first
// RULE12 - host saves constants after good calibration
// RULE13 - calibration writes gains of active mode
// RULE14 - calibration end copies thermistor to reference
// RULE15 - quantity offsets added after gain and shift
package mcd_pkg;
    // register offsets on the plain port
    localparam logic [4:0] A_GAIN0    = 5'h00; // 00..05: ac i,v,p then dc i,v,p
    localparam logic [4:0] A_GAIN_END = 5'h06;
    localparam logic [4:0] A_RANGE    = 5'h06;
    localparam logic [4:0] A_EXP_I    = 5'h07;
    localparam logic [4:0] A_EXP_V    = 5'h08;
    localparam logic [4:0] A_EXP_P    = 5'h09;
    localparam logic [4:0] A_PHASE    = 5'h0A;
    localparam logic [4:0] A_OFF_I    = 5'h0B;
    localparam logic [4:0] A_OFF_P    = 5'h0C;
    localparam logic [4:0] A_OFF_Q    = 5'h0D;
    localparam logic [4:0] A_DOFF_I   = 5'h0E;
    localparam logic [4:0] A_DOFF_P   = 5'h0F;
    localparam logic [4:0] A_UPPER    = 5'h10;
    localparam logic [4:0] A_LOW_I    = 5'h11;
    localparam logic [4:0] A_LOW_V    = 5'h12;
    localparam logic [4:0] A_CTRL     = 5'h13;
    localparam logic [4:0] A_STATUS   = 5'h14;
    localparam logic [4:0] A_AMB      = 5'h15;
    // field positions
    localparam int RNG_W    = 5;  // range field width, three fields i,v,p
    localparam int CTL_DC   = 0;  // control: dc mode
    localparam int CTL_GO   = 1;  // control: start gain calibration
    localparam int ST_BUSY  = 0;
    localparam int ST_ACK   = 1;
    localparam int ST_NAK   = 2;
    // reset values
    localparam logic [15:0] GAIN_RST  = 16'h8000;
    localparam logic [15:0] UPPER_RST = 16'hFFFF;
    localparam logic [15:0] LOW0_RST  = 16'h7D80;
    localparam logic [15:0] LOW1_RST  = 16'hEC00;
    // acceptance window and phase geometry
    localparam logic [15:0] GAIN_MIN  = 16'h61A8; // 25000
    localparam logic [15:0] GAIN_MAX  = 16'hFFFF; // 65535
    localparam int SAMPLES_PER_CYCLE  = 56;
    localparam int PHASE_STEPS        = 256;
    localparam int PHASE_SHIFT        = $clog2(PHASE_STEPS);
    localparam logic [4:0] DIV_LAST   = 5'h1F;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_LOAD = 2'b01,
        CAL_DIV  = 2'b10,
        CAL_END  = 2'b11
    } mcd_cal_e;

    // channel 0 current, channel 1 voltage
    typedef struct packed { logic [1:0][23:0] ch; } mcd_adc_s;
    // 0 irms, 1 vrms, 2 active, 3 reactive
    typedef struct packed { logic [3:0][23:0] v; } mcd_qty_s;
    typedef struct packed { logic [3:0][31:0] v; } mcd_res_s;

    typedef struct packed {
        logic [5:0][15:0] gain;
        logic [14:0]      range;
        logic [2:0][15:0] expv;
        logic [15:0]      phase;
        logic [4:0][15:0] off;
        logic [15:0]      upper;
        logic [1:0][15:0] low;
        logic             dc_mode;
        logic             busy;
        logic             ack;
        logic             nak;
        logic [9:0]       amb;
        logic [15:0]      rdata;
        logic             adc_ov;
        mcd_adc_s         adc_o;
        logic [1:0][23:0] prev;
        logic             hpf;
        logic             qov;
        mcd_res_s         qo;
        mcd_cal_e         cal;
        logic [1:0]       idx;
        logic [4:0]       cnt;
        logic [31:0]      num;
        logic [31:0]      den;
        logic [32:0]      rem;
        logic [31:0]      quo;
        logic [2:0][15:0] newg;
        logic             ok;
        logic             res_valid;
    } mcd_state_s;
endpackage

// file: design/mcd_datapath.sv
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath #(
    parameter logic [15:0] GAIN_LO = mcd_pkg::GAIN_MIN,
    parameter logic [15:0] GAIN_HI = mcd_pkg::GAIN_MAX
) (
    // clock and reset
    input  wire logic              clock,
    input  wire logic              reset,
    // register port
    input  wire logic [4:0]        reg_addr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [15:0]            reg_rdata,
    // converter codes
    input  wire logic              adc_valid,
    input  wire mcd_pkg::mcd_adc_s adc_in,
    output logic                   adc_out_valid,
    output mcd_pkg::mcd_adc_s      adc_out,
    output logic                   hpf_bypass,
    // quantities
    input  wire logic              qty_valid,
    input  wire mcd_pkg::mcd_qty_s qty_raw,
    output logic                   qty_out_valid,
    output mcd_pkg::mcd_res_s      qty_out,
    // temperature and calibration result
    input  wire logic [9:0]        thermistor,
    output logic                   cal_done,
    output logic                   cal_ack
);
    // acceptance window must be a real window
    if (GAIN_LO == 16'h0000 || GAIN_LO > GAIN_HI) begin : g_chk
        $error("gain window empty");
    end

    mcd_pkg::mcd_state_s s;          // all state
    mcd_pkg::mcd_state_s n;          // next state
    logic [2:0]          gb;         // gain bank base of active mode
    logic [8:0]          mag;        // phase step magnitude
    logic [23:0]         corr [2];   // offset-corrected codes
    logic signed [34:0]  slope [2];  // sample delta times step
    logic signed [40:0]  prod [4];   // quantity times gain
    logic signed [40:0]  shd [4];    // after range shift
    logic [15:0]         offs [4];   // offset picked per quantity
    logic [32:0]         rsh;        // divider partial remainder
    logic                pass;       // quotient inside window

    // next-state logic
    always_comb begin
        n = s;
        n.rdata = 16'h0000;
        n.res_valid = 1'b0;
        n.adc_ov = 1'b0;
        n.qov = 1'b0;
        n.hpf = s.dc_mode;  // see RULE7
        gb = s.dc_mode ? 3'h3 : 3'h0;

        // register writes
        if (reg_wr) begin
            if (reg_addr < mcd_pkg::A_GAIN_END) begin
                n.gain[reg_addr[2:0]] = reg_wdata;  // see RULE3
            end
            case (reg_addr)
                mcd_pkg::A_RANGE:  n.range = reg_wdata[14:0];
                mcd_pkg::A_EXP_I:  n.expv[0] = reg_wdata;
                mcd_pkg::A_EXP_V:  n.expv[1] = reg_wdata;
                mcd_pkg::A_EXP_P:  n.expv[2] = reg_wdata;
                mcd_pkg::A_PHASE:  n.phase = reg_wdata;
                mcd_pkg::A_OFF_I:  n.off[0] = reg_wdata;  // see RULE6
                mcd_pkg::A_OFF_P:  n.off[1] = reg_wdata;
                mcd_pkg::A_OFF_Q:  n.off[2] = reg_wdata;
                mcd_pkg::A_DOFF_I: n.off[3] = reg_wdata;  // see RULE8
                mcd_pkg::A_DOFF_P: n.off[4] = reg_wdata;
                mcd_pkg::A_UPPER:  n.upper = reg_wdata;   // see RULE10
                mcd_pkg::A_LOW_I:  n.low[0] = reg_wdata;
                mcd_pkg::A_LOW_V:  n.low[1] = reg_wdata;
                mcd_pkg::A_CTRL: begin
                    // mode is frozen while a calibration runs
                    if (!s.busy) begin
                        n.dc_mode = reg_wdata[mcd_pkg::CTL_DC];
                    end
                    if (reg_wdata[mcd_pkg::CTL_GO] && !s.busy) begin
                        n.busy = 1'b1;
                        n.ack = 1'b0;
                        n.nak = 1'b0;
                        n.ok = 1'b1;
                        n.idx = 2'h0;
                        n.cal = mcd_pkg::CAL_LOAD;
                    end
                end
                default: ;  // unmapped or read-only
            endcase
        end

        // register reads, data one cycle later
        if (reg_rd) begin
            if (reg_addr < mcd_pkg::A_GAIN_END) begin
                n.rdata = s.gain[reg_addr[2:0]];
            end
            case (reg_addr)
                mcd_pkg::A_RANGE:  n.rdata = {1'b0, s.range};
                mcd_pkg::A_EXP_I:  n.rdata = s.expv[0];
                mcd_pkg::A_EXP_V:  n.rdata = s.expv[1];
                mcd_pkg::A_EXP_P:  n.rdata = s.expv[2];
                mcd_pkg::A_PHASE:  n.rdata = s.phase;
                mcd_pkg::A_OFF_I:  n.rdata = s.off[0];
                mcd_pkg::A_OFF_P:  n.rdata = s.off[1];
                mcd_pkg::A_OFF_Q:  n.rdata = s.off[2];
                mcd_pkg::A_DOFF_I: n.rdata = s.off[3];
                mcd_pkg::A_DOFF_P: n.rdata = s.off[4];
                mcd_pkg::A_UPPER:  n.rdata = s.upper;
                mcd_pkg::A_LOW_I:  n.rdata = s.low[0];
                mcd_pkg::A_LOW_V:  n.rdata = s.low[1];
                mcd_pkg::A_CTRL:   n.rdata = {15'h0000, s.dc_mode};
                mcd_pkg::A_STATUS: n.rdata = {13'h0000, s.nak, s.ack, s.busy};
                mcd_pkg::A_AMB:    n.rdata = {6'h00, s.amb};
                default: ;  // unmapped reads as zero
            endcase
        end

        // converter path: offset first, then phase delay
        mag = s.phase[7] ? (9'h100 - {1'b0, s.phase[7:0]})
                         : {1'b0, s.phase[7:0]};  // see RULE5
        for (int c = 0; c < 2; c++) begin
            corr[c] = adc_in.ch[c]
                    + {s.upper[8*c +: 8], s.low[c]};  // see RULE9
            slope[c] = ($signed({corr[c][23], corr[c]})
                     - $signed({s.prev[c][23], s.prev[c]}))
                     * $signed({1'b0, mag});
            if (adc_valid) begin
                n.prev[c] = corr[c];
                // positive delays voltage, negative delays current
                if ((c == 1) != s.phase[7]) begin
                    n.adc_o.ch[c] = corr[c]
                        - 24'(slope[c] >>> mcd_pkg::PHASE_SHIFT);  // see RULE4
                end else begin
                    n.adc_o.ch[c] = corr[c];  // see RULE11
                end
            end
        end
        if (adc_valid) begin
            n.adc_ov = 1'b1;
        end

        // quantity path: gain, range shift, then offset
        for (int k = 0; k < 4; k++) begin
            // reactive shares the active gain and range
            prod[k] = $signed(qty_raw.v[k]) * $signed({1'b0,
                      s.gain[gb + 3'((k == 3) ? 2 : k)]});
            shd[k] = prod[k] >>> s.range[mcd_pkg::RNG_W * ((k == 3) ? 2 : k)
                     +: mcd_pkg::RNG_W];  // see RULE2
            case (k)
                0:       offs[k] = s.dc_mode ? s.off[3] : s.off[0];
                2:       offs[k] = s.dc_mode ? s.off[4] : s.off[1];
                3:       offs[k] = s.dc_mode ? 16'h0000 : s.off[2];
                default: offs[k] = 16'h0000;  // voltage has none
            endcase
            if (qty_valid) begin
                n.qo.v[k] = shd[k][31:0]
                          + {{16{offs[k][15]}}, offs[k]};  // see RULE15
            end
        end
        if (qty_valid) begin
            n.qov = 1'b1;
        end

        // gain calibration, one restoring division per quantity
        rsh = {s.rem[31:0], s.num[31]};
        pass = (s.quo >= {16'h0000, GAIN_LO})
            && (s.quo <= {16'h0000, GAIN_HI});  // see RULE1
        case (s.cal)
            mcd_pkg::CAL_IDLE: ;
            mcd_pkg::CAL_LOAD: begin
                n.num = s.gain[gb + {1'b0, s.idx}] * s.expv[s.idx];
                n.den = s.qo.v[s.idx];
                // zero or negative reading cannot calibrate
                if (s.qo.v[s.idx][31] || s.qo.v[s.idx] == 32'h0000_0000) begin
                    n.ok = 1'b0;
                end
                n.rem = 33'h0_0000_0000;
                n.quo = 32'h0000_0000;
                n.cnt = 5'h00;
                n.cal = mcd_pkg::CAL_DIV;
            end
            mcd_pkg::CAL_DIV: begin
                n.num = {s.num[30:0], 1'b0};
                if (rsh >= {1'b0, s.den}) begin
                    n.rem = rsh - {1'b0, s.den};
                    n.quo = {s.quo[30:0], 1'b1};
                end else begin
                    n.rem = rsh;
                    n.quo = {s.quo[30:0], 1'b0};
                end
                n.cnt = s.cnt + 5'h01;
                if (s.cnt == mcd_pkg::DIV_LAST) begin
                    n.cal = mcd_pkg::CAL_END;
                end
            end
            mcd_pkg::CAL_END: begin
                n.newg[s.idx] = s.quo[15:0];  // see RULE3
                n.ok = s.ok && pass;
                if (s.idx == 2'h2) begin
                    // all three inside the window or none written
                    if (s.ok && pass) begin
                        for (int q = 0; q < 2; q++) begin
                            n.gain[gb + 3'(q)] = s.newg[q];  // see RULE13
                        end
                        n.gain[gb + 3'h2] = s.quo[15:0];
                        n.ack = 1'b1;
                    end else begin
                        n.nak = 1'b1;
                    end
                    n.amb = thermistor;  // see RULE14
                    n.busy = 1'b0;
                    n.res_valid = 1'b1;
                    n.cal = mcd_pkg::CAL_IDLE;
                end else begin
                    n.idx = s.idx + 2'h1;
                    n.cal = mcd_pkg::CAL_LOAD;
                end
            end
            default: n.cal = mcd_pkg::CAL_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            s.gain <= {6{mcd_pkg::GAIN_RST}};
            s.upper <= mcd_pkg::UPPER_RST;
            s.low <= {mcd_pkg::LOW1_RST, mcd_pkg::LOW0_RST};
            s.cal <= mcd_pkg::CAL_IDLE;
        end else begin
            s <= n;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s.rdata;
    assign adc_out_valid = s.adc_ov;
    assign adc_out = s.adc_o;
    assign hpf_bypass = s.hpf;
    assign qty_out_valid = s.qov;
    assign qty_out = s.qo;
    assign cal_done = s.res_valid;
    assign cal_ack = s.ack;

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    hpf_follow_a: assert property (s.dc_mode ##1 s.dc_mode |-> hpf_bypass) // see RULE7
        else $error("filters not bypassed in dc mode");
    ack_window_a: assert property (s.res_valid && s.ack |-> // see RULE1
        s.gain[gb] >= GAIN_LO && s.gain[gb + 3'h2] >= GAIN_LO)
        else $error("accepted gain below window");
    one_answer_a: assert property (s.res_valid |-> s.ack != s.nak)
        else $error("calibration answer not unique");
    wide_reject_a: assert property (s.cal == mcd_pkg::CAL_END // see RULE3
        && s.quo > {16'h0000, GAIN_HI} |=> !s.ok)
        else $error("oversize gain accepted");
    range_shift_a: assert property (qty_valid && !s.dc_mode // see RULE2
        && s.range[4:0] == 5'h01 && s.off[0] == 16'h0000 |=>
        qty_out.v[0] == 32'(41'($signed($past(qty_raw.v[0]))
        * $signed({1'b0, $past(s.gain[0])})) >>> 1))
        else $error("one range step is not one shift");
    chan_offset_a: assert property (adc_valid // see RULE11
        && s.phase[7:0] == 8'h00 |=> adc_out.ch[0] == $past(adc_in.ch[0])
        + $past({s.upper[7:0], s.low[0]}) && adc_out.ch[1]
        == $past(adc_in.ch[1]) + $past({s.upper[15:8], s.low[1]}))
        else $error("channel offset wrong");
    amb_copy_a: assert property (s.cal == mcd_pkg::CAL_END // see RULE14
        && s.idx == 2'h2 |=> s.amb == $past(thermistor) && cal_done)
        else $error("reference not captured");
    mode_bank_a: assert property (s.res_valid && s.dc_mode |-> // see RULE13
        s.gain[0] == $past(s.gain[0]) && s.gain[2] == $past(s.gain[2]))
        else $error("ac gain touched in dc mode");

    ack_seen_c: cover property (cal_done && cal_ack && !s.dc_mode);
    nak_seen_c: cover property (cal_done && s.nak);
    dc_ack_c: cover property (cal_done && cal_ack && s.dc_mode);
    neg_phase_c: cover property (adc_valid && s.phase[7]);
endmodule
`default_nettype wire

// file: tb/mcd_host.sv
`timescale 1ns/1ps
`default_nettype none
// host model: plain register port master, driven by the bench through its tasks
module mcd_host (
    // clock
    input  wire logic        clock,
    // register port, master side
    output logic [4:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata
);
    int save_count; // saves asked for after accepted calibrations

    // idle bus from time zero
    initial begin
        reg_addr   = 5'h00;
        reg_wdata  = 16'h0000;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        save_count = 0;
    end

    // one-cycle write strobe with address and data beside it
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // constants only persist when the host asks; nothing to save on a refusal
    task automatic after_cal(input logic ack);
        if (ack === 1'b1) begin
            save_count++;
        end
    endtask
endmodule
`default_nettype wire

// file: tb/mcd_datapath_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcd_datapath_tb_top;
    logic              clock = 1'b0;    // 25 MHz
    logic              reset = 1'b1;    // synchronous, high
    logic [4:0]        reg_addr;        // from host model
    logic [15:0]       reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [15:0]       reg_rdata;
    logic              adc_valid = 1'b0; // converter strobe
    mcd_pkg::mcd_adc_s adc_in = '0;
    logic              adc_out_valid;
    mcd_pkg::mcd_adc_s adc_out;
    logic              hpf_bypass;
    logic              qty_valid = 1'b0; // quantity strobe
    mcd_pkg::mcd_qty_s qty_raw = '0;
    logic              qty_out_valid;
    mcd_pkg::mcd_res_s qty_out;
    logic [9:0]        thermistor = 10'h2A5; // first reading, changed before the dc calibration
    logic              cal_done;
    logic              cal_ack;
    int                num_errors = 0;
    int                tests_run = 0;
    int                cycles = 0;

    always #20 clock = ~clock;

    mcd_datapath u_mcd_datapath (
        .clock(clock), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .adc_valid(adc_valid), .adc_in(adc_in), .adc_out_valid(adc_out_valid),
        .adc_out(adc_out), .hpf_bypass(hpf_bypass), .qty_valid(qty_valid),
        .qty_raw(qty_raw), .qty_out_valid(qty_out_valid), .qty_out(qty_out),
        .thermistor(thermistor), .cal_done(cal_done), .cal_ack(cal_ack)
    );
    mcd_host u_mcd_host (
        .clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
    );

    // verdict and end of run, also reached from the hang guard
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // hang guard: the whole run needs well under a thousand cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            print_verdict();
        end
    end

    // four-state compare, counted
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask

    // register read and compare
    task automatic rchk(input string what, input logic [4:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_mcd_host.rd(a, d);
        chk(what, {16'h0000, e}, {16'h0000, d});
    endtask

    // one converter sample, output looked at in its answer cycle
    task automatic adc(input logic [23:0] i, input logic [23:0] v);
        @(posedge clock);
        adc_valid     <= 1'b1;
        adc_in.ch[0]  <= i;
        adc_in.ch[1]  <= v;
        @(posedge clock);
        adc_valid <= 1'b0;
        #1;
        chk("adc_out_valid", 32'h1, {31'h0, adc_out_valid});
    endtask

    // one quantity set: irms, vrms, active, reactive
    task automatic qty(input logic [23:0] i, v, p, q);
        @(posedge clock);
        qty_valid    <= 1'b1;
        qty_raw.v[0] <= i;
        qty_raw.v[1] <= v;
        qty_raw.v[2] <= p;
        qty_raw.v[3] <= q;
        @(posedge clock);
        qty_valid <= 1'b0;
        #1;
        chk("qty_out_valid", 32'h1, {31'h0, qty_out_valid});
    endtask

    // start gain calibration and wait a bounded time for its end pulse
    task automatic cal_run(input logic dc);
        int n;
        n = 0;
        u_mcd_host.wr(mcd_pkg::A_CTRL, {14'h0000, 1'b1, dc});
        rchk("busy", mcd_pkg::A_STATUS, 16'h0001);
        while (cal_done !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk("cal_done", 32'h1, {31'h0, cal_done});
    endtask

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        // reset values and an unmapped read
        rchk("gain", mcd_pkg::A_GAIN0, 16'h8000);
        rchk("upper", mcd_pkg::A_UPPER, 16'hFFFF);
        rchk("low_i", mcd_pkg::A_LOW_I, 16'h7D80);
        rchk("low_v", mcd_pkg::A_LOW_V, 16'hEC00);
        rchk("unmapped", 5'h1F, 16'h0000);
        $display("test reset values done");
        // distinct bytes show which upper byte lands on which channel
        u_mcd_host.wr(mcd_pkg::A_UPPER, 16'h0102);
        u_mcd_host.wr(mcd_pkg::A_LOW_I, 16'h0304);
        u_mcd_host.wr(mcd_pkg::A_LOW_V, 16'h0506);
        adc(24'h000010, 24'h000020);
        chk("adc_i", 32'h020314, {8'h00, adc_out.ch[0]});
        chk("adc_v", 32'h010526, {8'h00, adc_out.ch[1]});
        $display("test channel offsets done");
        // phase: high byte is noise, low byte signed
        u_mcd_host.wr(mcd_pkg::A_UPPER, 16'h0000);
        u_mcd_host.wr(mcd_pkg::A_LOW_I, 16'h0000);
        u_mcd_host.wr(mcd_pkg::A_LOW_V, 16'h0000);
        u_mcd_host.wr(mcd_pkg::A_PHASE, 16'h1240);
        adc(24'h000100, 24'h000100);
        adc(24'h000100, 24'h000200);
        chk("ph_v", 32'h0001C0, {8'h00, adc_out.ch[1]});
        chk("ph_i", 32'h000100, {8'h00, adc_out.ch[0]});
        u_mcd_host.wr(mcd_pkg::A_PHASE, 16'h12C0);
        adc(24'h000300, 24'h000200);
        chk("ph_neg_i", 32'h000280, {8'h00, adc_out.ch[0]});
        chk("ph_neg_v", 32'h000200, {8'h00, adc_out.ch[1]});
        $display("test phase done");
        // calibration: range 15 cancels gain 0x8000, so measured equals raw
        u_mcd_host.wr(mcd_pkg::A_RANGE, 16'h3DEF);
        u_mcd_host.wr(mcd_pkg::A_EXP_I, 16'h03E8);
        u_mcd_host.wr(mcd_pkg::A_EXP_V, 16'h0FA1);
        u_mcd_host.wr(mcd_pkg::A_EXP_P, 16'h0C1C);
        qty(24'h0003E8, 24'h0007D0, 24'h000FA0, 24'h000000);
        chk("meas_v", 32'h000007D0, qty_out.v[1]);
        cal_run(1'b0);
        chk("cal_ack_nak", 32'h0, {31'h0, cal_ack});
        rchk("gain_v_kept", 5'h01, 16'h8000);
        rchk("status_nak", mcd_pkg::A_STATUS, 16'h0004);
        u_mcd_host.wr(mcd_pkg::A_EXP_V, 16'h0BB8);
        cal_run(1'b0);
        chk("cal_ack", 32'h1, {31'h0, cal_ack});
        u_mcd_host.after_cal(cal_ack);
        rchk("gain_i", 5'h00, 16'h8000);
        rchk("gain_v", 5'h01, 16'hC000);
        rchk("gain_p", 5'h02, 16'h6333);
        rchk("dc_gain_i", 5'h03, 16'h8000);
        rchk("dc_gain_p", 5'h05, 16'h8000);
        rchk("ambient", mcd_pkg::A_AMB, 16'h02A5);
        $display("test gain calibration done");
        // ac quantities: shifts per field, offsets after shift
        u_mcd_host.wr(5'h02, 16'h8000);
        u_mcd_host.wr(mcd_pkg::A_RANGE, 16'h9403);
        rchk("range", mcd_pkg::A_RANGE, 16'h1403);
        u_mcd_host.wr(mcd_pkg::A_OFF_I, 16'h0010);
        u_mcd_host.wr(mcd_pkg::A_OFF_P, 16'hFFF0);
        u_mcd_host.wr(mcd_pkg::A_OFF_Q, 16'h0005);
        qty(24'h000100, 24'h000200, 24'h000300, 24'h000400);
        chk("q_irms", 32'h00100010, qty_out.v[0]);
        chk("q_vrms", 32'h01800000, qty_out.v[1]);
        chk("q_act", 32'h000BFFF0, qty_out.v[2]);
        chk("q_react", 32'h00100005, qty_out.v[3]);
        chk("hpf_ac", 32'h0, {31'h0, hpf_bypass});
        // one range step halves the current product
        u_mcd_host.wr(mcd_pkg::A_OFF_I, 16'h0000);
        u_mcd_host.wr(mcd_pkg::A_RANGE, 16'h1401);
        qty(24'h000100, 24'h000200, 24'h000300, 24'h000400);
        chk("q_irms_r1", 32'h00400000, qty_out.v[0]);
        u_mcd_host.wr(mcd_pkg::A_RANGE, 16'h1403);
        // dc mode: own offsets, no reactive offset, filters bypassed
        u_mcd_host.wr(mcd_pkg::A_DOFF_I, 16'h0020);
        u_mcd_host.wr(mcd_pkg::A_DOFF_P, 16'h0007);
        u_mcd_host.wr(mcd_pkg::A_CTRL, 16'h0001);
        qty(24'h000100, 24'h000200, 24'h000300, 24'h000400);
        chk("hpf_bypass", 32'h1, {31'h0, hpf_bypass});
        chk("dq_irms", 32'h00100020, qty_out.v[0]);
        chk("dq_act", 32'h000C0007, qty_out.v[2]);
        chk("dq_react", 32'h00100000, qty_out.v[3]);
        $display("test quantity offsets done");
        // dc calibration: only the dc bank moves, fresh temperature copied
        u_mcd_host.wr(mcd_pkg::A_RANGE, 16'h3DEF);
        thermistor <= 10'h1C3;
        qty(24'h0003C8, 24'h0007D0, 24'h000F99, 24'h000000);
        cal_run(1'b1);
        chk("dc_cal_ack", 32'h1, {31'h0, cal_ack});
        u_mcd_host.after_cal(cal_ack);
        rchk("dc_gain_v", 5'h04, 16'hC000);
        rchk("dc_gain_p2", 5'h05, 16'h6333);
        rchk("ac_gain_p", 5'h02, 16'h8000);
        rchk("ambient2", mcd_pkg::A_AMB, 16'h01C3);
        chk("saves", 32'h2, u_mcd_host.save_count);
        $display("test dc calibration done");
        print_verdict();
    end
endmodule
`default_nettype wire
